// File: logic/agss_pkg.sv
// Constants and types shared by the group sampling sequencer.
// Assumes a single 50 MHz clock domain and classic Wishbone register access.
package agss_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_HZ       = 50_000_000;
	localparam int unsigned CONV_TIME_NS = 2000;
	// Converter busy time in clock cycles, rounded up
	localparam int unsigned CONV_CYC     = (CONV_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	// Tail after the last sample period; one cycle goes to the group restart
	localparam logic [15:0] TAIL_LOAD    = 16'(CONV_CYC - 2);
	localparam logic [15:0] CONV_LOAD    = 16'(CONV_CYC);

	// ****************************************
	// Register map (byte offsets)
	// ****************************************
	localparam logic [4:0] ADR_CTRL  = 5'h00;
	localparam logic [4:0] ADR_FREQ  = 5'h04;
	localparam logic [4:0] ADR_LOOPS = 5'h08;
	localparam logic [4:0] ADR_WAIT  = 5'h0c;
	localparam logic [4:0] ADR_CHAN  = 5'h10;
	localparam logic [4:0] ADR_STAT  = 5'h14;
	localparam logic [4:0] ADR_DATA  = 5'h18;

	// Control bits and field positions
	localparam int CTRL_RUN   = 0;
	localparam int CTRL_GROUP = 1;
	localparam int CTRL_EXT   = 2;
	localparam int CTRL_FALL  = 3;
	localparam int CHAN_HI_POS = 8;
	localparam int DATA_VALID  = 31;

	// Values after reset
	localparam logic [3:0]  CTRL_RST  = 4'h0;
	localparam logic [31:0] FREQ_RST  = 32'h0001_86a0;
	localparam logic [7:0]  LOOPS_RST = 8'h01;
	localparam logic [31:0] WAIT_RST  = 32'h0000_09c4;

	typedef enum logic [2:0] {ST_IDLE, ST_SWEEP, ST_LASTPER, ST_CONVT, ST_GAP, ST_EXTWAIT} agss_state_type;
endpackage

// File: logic/agss_stream_if.sv
// Valid/ready word stream between the sequencer and its FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface agss_stream_if #(
	parameter int W = 21
)();
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// File: logic/agss_edge_sync.sv
// Three-stage synchroniser and edge detector for the external sampling clock.
// Assumes the pin is asynchronous to mclk and far slower than it.
`timescale 1ns/1ps
module agss_edge_sync (
	input  wire logic mclk,
	input  wire logic arst_n,
	input  wire logic pinIn,
	input  wire logic fallSel,
	output logic      edgePulse
);
	logic [2:0] sync_r;
	logic       level_r;

	// A change counts once stages two and three agree on it
	wire settled = sync_r[2] == sync_r[1];
	wire newEdge = settled & (sync_r[2] != level_r) & (sync_r[2] != fallSel);

	// Sample chain, settled level and registered edge pulse
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync_r    <= 3'h0;
			level_r   <= 1'b0;
			edgePulse <= 1'b0;
		end
		else
		begin
			sync_r    <= {sync_r[1:0], pinIn};
			level_r   <= settled ? sync_r[2] : level_r;
			edgePulse <= newEdge;
		end
	end
endmodule

// File: logic/agss_fifo.sv
// Sample FIFO with parameter width and depth and a registered read port.
// Assumes DEPTH is a power of two.
`timescale 1ns/1ps
module agss_fifo #(
	parameter int WIDTH = 21,
	parameter int DEPTH = 8
)(
	input  wire logic   mclk,
	input  wire logic   arst_n,
	agss_stream_if.snk  inPort,
	agss_stream_if.src  outPort
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_r;
	logic [AW-1:0]    rdPtr_r;
	logic [AW:0]      count_r;
	logic             outValid_r;
	logic [WIDTH-1:0] outData_r;

	// Output register counts toward the depth, so exactly DEPTH words fit
	wire [AW:0] level = count_r + (AW+1)'(outValid_r);

	// Fill side stalls when full; output stage refills when empty or taken
	assign inPort.ready  = level != (AW+1)'(DEPTH);
	assign outPort.valid = outValid_r;
	assign outPort.data  = outData_r;
	wire doWr = inPort.valid & inPort.ready;
	wire doRd = (count_r != '0) & (!outValid_r | outPort.ready);

	// Storage has no reset
	always_ff @(posedge mclk)
	begin
		if (doWr)
			mem[wrPtr_r] <= inPort.data;
	end

	// Pointers, level and output register
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wrPtr_r    <= '0;
			rdPtr_r    <= '0;
			count_r    <= '0;
			outValid_r <= 1'b0;
			outData_r  <= '0;
		end
		else
		begin
			wrPtr_r <= doWr ? wrPtr_r + 1'b1 : wrPtr_r;
			rdPtr_r <= doRd ? rdPtr_r + 1'b1 : rdPtr_r;
			count_r <= count_r + (AW+1)'(doWr) - (AW+1)'(doRd);
			if (doRd)
			begin
				outData_r  <= mem[rdPtr_r];
				outValid_r <= 1'b1;
			end
			else if (outPort.ready)
				outValid_r <= 1'b0;
		end
	end

	out_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
		outPort.valid && !outPort.ready |=> outPort.valid && $stable(outPort.data))
		else $error("FIFO head changed while stalled");
endmodule

// File: logic/agss_sequencer.sv
// Group sampling sequencer: paces converter starts, Wishbone registers, sample FIFO.
// Assumes one 50 MHz clock, an asynchronous external sampling clock pin and a
// converter whose result is stable on convData once the conversion time has passed.
//
// Behaviour
// - Continuous mode: starts evenly spaced, no pause
// - Start spacing is one over programmed frequency
// - Grouping: sweep group, wait, repeat forever
// - Sweep full range per loop, loop count times
// - Channel count is high minus low plus one
// - Period: samples, conversion time and wait summed
// - After last conversion, idle until wait ends
// - One set of group data per period
// - External mode: edge starts group, then idle
// - Edges during a group are ignored
// - External mode group period equals clock period
// - Rate, loops and wait programmed separately
`timescale 1ns/1ps
module agss_sequencer #(
	parameter int CHAN_W     = 5,
	parameter int DATA_W     = 16,
	parameter int FIFO_DEPTH = 8
)(
	input  wire logic              mclk,
	input  wire logic              arst_n,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [4:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	input  wire logic              extClkPin,
	input  wire logic [DATA_W-1:0] convData,
	output logic                   convStart,
	output logic      [CHAN_W-1:0] convChannel
);
	localparam int FW = CHAN_W + DATA_W;

	// ****************************************
	// Declarations
	// ****************************************
	logic [3:0]          acquisitionModeSelect_r;
	logic [31:0]         sampleFreq_r;
	logic [7:0]          perGroupSweepCount_r;
	logic [31:0]         interGroupWait_r;
	logic [CHAN_W-1:0]   rangeLowChannel_r;
	logic [CHAN_W-1:0]   rangeHighChannel_r;
	logic                ack_r;
	logic [31:0]         datO_r;
	logic [31:0]         acc_r;
	logic [31:0]         acc_nxt;
	agss_pkg::agss_state_type state_r;
	agss_pkg::agss_state_type state_nxt;
	logic [CHAN_W-1:0]   chan_r;
	logic [CHAN_W-1:0]   chan_nxt;
	logic [7:0]          loop_r;
	logic [7:0]          loop_nxt;
	logic                kick_r;
	logic                kick_nxt;
	logic [15:0]         tail_r;
	logic [15:0]         tail_nxt;
	logic [31:0]         gap_r;
	logic [31:0]         gap_nxt;
	logic [15:0]         convCnt_r;
	logic [CHAN_W-1:0]   convChan_r;
	logic [7:0]          ignored_r;
	logic                extEdge;
	logic [31:0]         readMux;

	agss_stream_if #(.W(FW)) pushIf ();
	agss_stream_if #(.W(FW)) popIf ();

	// ****************************************
	// Wishbone slave
	// ****************************************

	// Byte-lane merge of a write into a register image
	function automatic logic [31:0] agssMerge(input logic [31:0] old, input logic [31:0] dat,
		input logic [3:0] sel);
		logic [31:0] mask;
		mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (old & ~mask) | (dat & mask);
	endfunction

	// Request decode: ack one cycle after the request, writes land at the ack edge
	wire wbReq   = wb_cyc_i & wb_stb_i;
	wire wbWr    = wbReq & ack_r & wb_we_i;
	wire wbRd    = wbReq & ack_r & !wb_we_i;
	wire selCtrl = wb_adr_i[4:2] == agss_pkg::ADR_CTRL[4:2];
	wire selFreq = wb_adr_i[4:2] == agss_pkg::ADR_FREQ[4:2];
	wire selLoop = wb_adr_i[4:2] == agss_pkg::ADR_LOOPS[4:2];
	wire selWait = wb_adr_i[4:2] == agss_pkg::ADR_WAIT[4:2];
	wire selChan = wb_adr_i[4:2] == agss_pkg::ADR_CHAN[4:2];
	wire selStat = wb_adr_i[4:2] == agss_pkg::ADR_STAT[4:2];
	wire selData = wb_adr_i[4:2] == agss_pkg::ADR_DATA[4:2];
	assign wb_ack_o = ack_r;
	assign wb_dat_o = datO_r;

	// Register images as seen by the bus
	wire [31:0] chanImg = {16'h0000, 3'h0, rangeHighChannel_r, 3'h0, rangeLowChannel_r};
	wire [31:0] statImg = {8'h00, ignored_r, 3'h0, chan_r, 4'h0,
		popIf.valid, state_r == agss_pkg::ST_EXTWAIT, state_r == agss_pkg::ST_GAP,
		state_r != agss_pkg::ST_IDLE};
	wire [31:0] dataImg = {popIf.valid, {(31-FW){1'b0}}, popIf.data};

	// Byte-merged write images of the narrow registers
	wire [31:0] ctrlMrg = agssMerge({28'h0000000, acquisitionModeSelect_r}, wb_dat_i, wb_sel_i);
	wire [31:0] loopMrg = agssMerge({24'h000000, perGroupSweepCount_r}, wb_dat_i, wb_sel_i);
	wire [31:0] chanMrg = agssMerge(chanImg, wb_dat_i, wb_sel_i);

	// Read selection; unmapped offsets read zero
	assign readMux = selCtrl ? {28'h0000000, acquisitionModeSelect_r} :
		selFreq ? sampleFreq_r :
		selLoop ? {24'h000000, perGroupSweepCount_r} :
		selWait ? interGroupWait_r :
		selChan ? chanImg :
		selStat ? statImg :
		selData ? dataImg : 32'h0000_0000;

	// Pop only the head that the read returned; a word arriving after the request stays queued
	assign popIf.ready = wbRd & selData & datO_r[agss_pkg::DATA_VALID];

	// Ack and read data registers
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ack_r  <= 1'b0;
			datO_r <= 32'h0000_0000;
		end
		else
		begin
			ack_r  <= wbReq & !ack_r;
			datO_r <= (wbReq & !ack_r) ? readMux : datO_r;
		end
	end

	// Configuration registers, each with its own address
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			acquisitionModeSelect_r <= agss_pkg::CTRL_RST;
			sampleFreq_r            <= agss_pkg::FREQ_RST;
			perGroupSweepCount_r    <= agss_pkg::LOOPS_RST;
			interGroupWait_r        <= agss_pkg::WAIT_RST;
			rangeLowChannel_r       <= '0;
			rangeHighChannel_r      <= CHAN_W'(1);
		end
		else if (wbWr)
		begin
			if (selCtrl)
				acquisitionModeSelect_r <= ctrlMrg[3:0];
			if (selFreq)
				sampleFreq_r <= agssMerge(sampleFreq_r, wb_dat_i, wb_sel_i);
			if (selLoop)
				perGroupSweepCount_r <= loopMrg[7:0];
			if (selWait)
				interGroupWait_r <= agssMerge(interGroupWait_r, wb_dat_i, wb_sel_i);
			if (selChan)
			begin
				rangeLowChannel_r  <= chanMrg[CHAN_W-1:0];
				rangeHighChannel_r <= chanMrg[agss_pkg::CHAN_HI_POS +: CHAN_W];
			end
		end
	end

	// ****************************************
	// Sample rate generator
	// ****************************************

	// Mode bits and the phase accumulator's overflow test
	wire        run       = acquisitionModeSelect_r[agss_pkg::CTRL_RUN];
	wire        groupMode = acquisitionModeSelect_r[agss_pkg::CTRL_GROUP];
	wire        extMode   = acquisitionModeSelect_r[agss_pkg::CTRL_EXT] & groupMode;
	wire [32:0] accSum    = {1'b0, acc_r} + {1'b0, sampleFreq_r};
	wire        ncoHit    = accSum >= 33'(agss_pkg::CLK_HZ);
	wire        tick      = kick_r | ncoHit;
	wire        room      = pushIf.ready;
	wire        sweeping  = state_r == agss_pkg::ST_SWEEP;
	wire        startNow  = sweeping & tick & room;
	wire        hold      = sweeping & tick & !room;

	// Accumulator restarts at group start, holds once a start is due while the FIFO is full
	always_comb
	begin
		if (hold)
			acc_nxt = acc_r;
		else if (kick_r)
			acc_nxt = 32'h0000_0000;
		else if (ncoHit)
			acc_nxt = 32'(accSum - 33'(agss_pkg::CLK_HZ));
		else
			acc_nxt = accSum[31:0];
	end

	// ****************************************
	// Group sequencer
	// ****************************************

	wire lastInRange = chan_r == rangeHighChannel_r;
	wire lastLoop    = ({1'b0, loop_r} + 9'h001) >= {1'b0, perGroupSweepCount_r};

	// Next state and counters
	always_comb
	begin
		state_nxt = state_r;
		chan_nxt  = chan_r;
		loop_nxt  = loop_r;
		kick_nxt  = kick_r & !startNow;
		tail_nxt  = tail_r;
		gap_nxt   = gap_r;
		case (state_r)
			agss_pkg::ST_IDLE:
			begin
				chan_nxt = rangeLowChannel_r;
				loop_nxt = 8'h00;
				if (run)
				begin
					state_nxt = extMode ? agss_pkg::ST_EXTWAIT : agss_pkg::ST_SWEEP;
					kick_nxt  = !extMode;
				end
			end
			agss_pkg::ST_SWEEP:
			begin
				if (startNow)
				begin
					chan_nxt = lastInRange ? rangeLowChannel_r : chan_r + 1'b1;
					if (lastInRange && groupMode)
					begin
						loop_nxt  = lastLoop ? 8'h00 : loop_r + 8'h01;
						state_nxt = lastLoop ? agss_pkg::ST_LASTPER : agss_pkg::ST_SWEEP;
					end
				end
			end
			agss_pkg::ST_LASTPER:
			begin
				// The last sample period runs out before the tail starts
				if (ncoHit)
				begin
					state_nxt = agss_pkg::ST_CONVT;
					tail_nxt  = agss_pkg::TAIL_LOAD;
				end
			end
			agss_pkg::ST_CONVT:
			begin
				tail_nxt = tail_r - 16'h0001;
				if (tail_r == 16'h0000)
				begin
					if (extMode)
						state_nxt = agss_pkg::ST_EXTWAIT;
					else if (interGroupWait_r == 32'h0000_0000)
					begin
						state_nxt = agss_pkg::ST_SWEEP;
						kick_nxt  = 1'b1;
					end
					else
					begin
						state_nxt = agss_pkg::ST_GAP;
						gap_nxt   = interGroupWait_r - 32'h0000_0001;
					end
				end
			end
			agss_pkg::ST_GAP:
			begin
				gap_nxt = gap_r - 32'h0000_0001;
				if (gap_r == 32'h0000_0000)
				begin
					state_nxt = agss_pkg::ST_SWEEP;
					kick_nxt  = 1'b1;
				end
			end
			agss_pkg::ST_EXTWAIT:
			begin
				if (extEdge)
				begin
					state_nxt = agss_pkg::ST_SWEEP;
					kick_nxt  = 1'b1;
				end
			end
			default:
				state_nxt = agss_pkg::ST_IDLE;
		endcase
		if (!run)
		begin
			state_nxt = agss_pkg::ST_IDLE;
			kick_nxt  = 1'b0;
		end
	end

	// Sequencer registers
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_r <= agss_pkg::ST_IDLE;
			acc_r   <= 32'h0000_0000;
			chan_r  <= '0;
			loop_r  <= 8'h00;
			kick_r  <= 1'b0;
			tail_r  <= 16'h0000;
			gap_r   <= 32'h0000_0000;
		end
		else
		begin
			state_r <= state_nxt;
			acc_r   <= acc_nxt;
			chan_r  <= chan_nxt;
			loop_r  <= loop_nxt;
			kick_r  <= kick_nxt;
			tail_r  <= tail_nxt;
			gap_r   <= gap_nxt;
		end
	end

	// In external mode, edges outside the external wait are counted and dropped
	wire dropEdge = extEdge & extMode & (state_r != agss_pkg::ST_EXTWAIT);

	// ****************************************
	// Converter control and result capture
	// ****************************************

	// Result is taken once the fixed conversion time has run out
	assign pushIf.valid = convCnt_r == 16'h0001;
	assign pushIf.data  = {convChan_r, convData};

	// Start pulse, channel, conversion timer and dropped edge count
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			convStart   <= 1'b0;
			convChannel <= '0;
			convChan_r  <= '0;
			convCnt_r   <= 16'h0000;
			ignored_r   <= 8'h00;
		end
		else
		begin
			convStart   <= startNow;
			convChannel <= startNow ? chan_r : convChannel;
			convChan_r  <= startNow ? chan_r : convChan_r;
			convCnt_r   <= startNow ? agss_pkg::CONV_LOAD :
				(convCnt_r != 16'h0000) ? convCnt_r - 16'h0001 : convCnt_r;
			ignored_r   <= dropEdge ? ignored_r + 8'h01 : ignored_r;
		end
	end

	// ****************************************
	// Submodules
	// ****************************************
	agss_edge_sync u_sync (
		.mclk      (mclk),
		.arst_n    (arst_n),
		.pinIn     (extClkPin),
		.fallSel   (acquisitionModeSelect_r[agss_pkg::CTRL_FALL]),
		.edgePulse (extEdge)
	);

	agss_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.mclk    (mclk),
		.arst_n  (arst_n),
		.inPort  (pushIf),
		.outPort (popIf)
	);

	// ****************************************
	// Checks
	// ****************************************

	// Cycles since the last start, and whether the FIFO stalled or the accumulator restarted meanwhile
	logic [31:0] since_r;
	logic        stall_r;
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			since_r <= 32'h0000_0000;
			stall_r <= 1'b1;
		end
		else
		begin
			since_r <= convStart ? 32'h0000_0001 : since_r + 32'h0000_0001;
			stall_r <= convStart ? (hold | kick_r) : (stall_r | hold | kick_r);
		end
	end

	even_spacing_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		convStart && !groupMode && !stall_r && $stable(sampleFreq_r)
			&& (agss_pkg::CLK_HZ % sampleFreq_r == 0)
		|-> since_r == agss_pkg::CLK_HZ / sampleFreq_r)
		else $error("Continuous starts not evenly spaced");

	chan_range_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		convStart |-> convChannel >= rangeLowChannel_r && convChannel <= rangeHighChannel_r)
		else $error("Channel outside programmed range");

	loop_end_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		$rose(state_r == agss_pkg::ST_LASTPER)
		|-> $past(lastInRange) && $past(lastLoop) && chan_r == rangeLowChannel_r)
		else $error("Group ended before all loops swept");

	quiet_tail_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		state_r inside {agss_pkg::ST_CONVT, agss_pkg::ST_GAP, agss_pkg::ST_EXTWAIT} |=> !convStart)
		else $error("Conversion started during group wait");

	gap_length_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		$rose(state_r == agss_pkg::ST_GAP) && $stable(interGroupWait_r) && interGroupWait_r < 32'd200
		|-> (state_r == agss_pkg::ST_GAP)[*1] ##0 gap_r == interGroupWait_r - 32'h0000_0001)
		else $error("Inter-group wait loaded wrongly");

	edge_ignored_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		extEdge && run && state_r == agss_pkg::ST_CONVT && tail_r != 16'h0000 |=> state_r == agss_pkg::ST_CONVT)
		else $error("External edge disturbed a running group");

	edge_start_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		extEdge && run && extMode && state_r == agss_pkg::ST_EXTWAIT
		|=> state_r == agss_pkg::ST_SWEEP && kick_r ##1 (convStart || !$past(room)))
		else $error("External edge did not start a group");

	conv_result_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		convStart && room |-> ##99 (pushIf.valid && pushIf.ready))
		else $error("Result not stored after conversion time");

	wb_ack_a: assert property (
		@(posedge mclk) disable iff (!arst_n)
		wbReq && !ack_r |=> ack_r ##1 !ack_r)
		else $error("Wishbone ack not a single cycle");
endmodule

// File: tb/agss_far_model.sv
// Behavioural converter and external sampling clock source.
// Assumes convStart is a one-cycle pulse and convData is sampled 99 cycles later.
`timescale 1ns/1ps
module agss_far_model (
	input  wire logic        mclk,
	input  wire logic        convStart,
	input  wire logic [4:0]  convChannel,
	output logic      [15:0] convData,
	output logic             extClkPin
);
	logic [7:0] holdCnt_r = 8'h00;

	initial
	begin
		convData = 16'h0000;
		extClkPin = 1'b0;
	end

	// ****************************************
	// Converter result
	// ****************************************
	// Result held through the conversion, then scrambled every cycle
	always @(posedge mclk)
	begin
		if (convStart === 1'b1)
		begin
			convData <= {3'h5, convChannel, 3'h2, convChannel};
			holdCnt_r <= 8'h68;
		end
		else if (holdCnt_r != 8'h00)
			holdCnt_r <= holdCnt_r - 8'h01;
		else
			convData <= ~convData; // Stale data matches only on every second cycle
	end

	// One clock pulse; callers space edges as the scenario demands
	task automatic ext_pulse(input int hiCyc);
		extClkPin <= 1'b1;
		repeat (hiCyc) @(posedge mclk);
		extClkPin <= 1'b0;
	endtask
endmodule

// File: tb/adc_group_sampling_sequencer_tb.sv
// Self-checking bench for the group sampling sequencer.
// Assumes the far side model and a Wishbone master built here.
`timescale 1ns/1ps
module adc_group_sampling_sequencer_tb;
	typedef struct {logic [31:0] val; logic [31:0] mask;} agss_rd_type;
	typedef struct {logic [4:0] ch; int gap;} agss_st_type;
	logic        mclk = 1'b0;
	logic        arst_n = 1'b0;
	logic        wbCyc = 1'b0;
	logic        wbStb = 1'b0;
	logic        wbWe = 1'b0;
	logic [4:0]  wbAdr = 5'h00;
	logic [3:0]  wbSel = 4'hf;
	logic [31:0] wbDatI = 32'h0;
	logic [31:0] wbDatO;
	logic        wbAck;
	logic        extClkPin;
	logic [15:0] convData;
	logic        convStart;
	logic [4:0]  convChannel;
	int          bad_count = 0;
	int          num_checks = 0;
	int          cycleCnt = 0;
	int          startCount = 0;
	int          lastStart = 0;
	agss_rd_type rdExp[$];
	agss_st_type stExp[$];

	always #10 mclk = ~mclk;

	agss_sequencer DUT (.mclk(mclk), .arst_n(arst_n),
		.wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
		.wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .extClkPin(extClkPin),
		.convData(convData), .convStart(convStart), .convChannel(convChannel));

	agss_far_model FAR (.mclk(mclk), .convStart(convStart), .convChannel(convChannel),
		.convData(convData), .extClkPin(extClkPin));

	// ****************************************
	// Checking and reporting
	// ****************************************
	task automatic report_and_stop;
		$display("Counts: %0d checks, %0d mismatches", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check_read(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD read t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check_start(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD start t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Expected data word for a channel, matching the model's pattern
	function automatic logic [31:0] exp_word(input logic [4:0] c);
		return {1'b1, 10'h000, c, 3'h5, c, 3'h2, c};
	endfunction

	// Read results: oldest note against the word taken at the ack edge
	always @(posedge mclk)
	begin : readChk
		agss_rd_type r;
		if (wbCyc && wbStb && !wbWe && wbAck === 1'b1 && rdExp.size() > 0)
		begin
			r = rdExp.pop_front();
			check_read(wbDatO & r.mask, r.val);
		end
	end

	// Start results: channel and spacing in cycles; also the hang limit
	always @(posedge mclk)
	begin : startChk
		agss_st_type s;
		cycleCnt++;
		if (convStart === 1'b1)
		begin
			startCount++;
			if (stExp.size() == 0)
				check_start({27'h0, convChannel}, 32'hffffffff);
			else
			begin
				s = stExp.pop_front();
				if (s.gap == 0)
					check_start({27'h0, convChannel}, {27'h0, s.ch});
				else
					check_start({27'(cycleCnt - lastStart), convChannel}, {27'(s.gap), s.ch});
			end
			lastStart = cycleCnt;
		end
		if (cycleCnt > 8000)
		begin
			bad_count++;
			report_and_stop();
		end
	end

	// ****************************************
	// Bus master and scenarios
	// ****************************************
	// Classic cycle: hold until ack is sampled, release, then one idle cycle
	task automatic wb_xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= w;
		wbAdr <= a;
		wbDatI <= d;
		repeat (50)
		begin
			@(posedge mclk);
			if (wbAck === 1'b1)
				break;
		end
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] v, input logic [31:0] m);
		rdExp.push_back('{v & m, m});
		wb_xfer(1'b0, a, 32'h0);
	endtask

	task automatic wait_starts(input int n);
		repeat (3000)
		begin
			if (startCount >= n)
				break;
			@(posedge mclk);
		end
		repeat (110) @(posedge mclk);
	endtask

	// Main sequence
	initial
	begin
		int i;
		int waitV;
		void'($urandom(58));
		repeat (5) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		rd(agss_pkg::ADR_CTRL, 32'h0, 32'hf);
		rd(agss_pkg::ADR_FREQ, agss_pkg::FREQ_RST, 32'hffffffff);
		rd(agss_pkg::ADR_LOOPS, 32'(agss_pkg::LOOPS_RST), 32'hff);
		rd(agss_pkg::ADR_WAIT, agss_pkg::WAIT_RST, 32'hffffffff);
		rd(agss_pkg::ADR_CHAN, 32'h0100, 32'h1f1f);
		rd(5'h1c, 32'h0, 32'hffffffff);
		// Only byte one enabled: the loop count must not change
		wbSel <= 4'h2;
		wb_xfer(1'b1, agss_pkg::ADR_LOOPS, 32'h0000_0305);
		wbSel <= 4'hf;
		rd(agss_pkg::ADR_LOOPS, 32'(agss_pkg::LOOPS_RST), 32'hff);
		$display("Test reset values done");
		// Continuous at 125 cycles a start, run until the FIFO refuses
		for (i = 0; i < 8; i++)
			stExp.push_back('{5'(i % 2), (i == 0) ? 0 : 125});
		wb_xfer(1'b1, agss_pkg::ADR_FREQ, 32'd400000);
		wb_xfer(1'b1, agss_pkg::ADR_CTRL, 32'h1);
		wait_starts(8);
		repeat (200) @(posedge mclk);
		rd(agss_pkg::ADR_STAT, 32'h8, 32'h8);
		check_read(32'(startCount), 32'd8);
		wb_xfer(1'b1, agss_pkg::ADR_CTRL, 32'h0);
		for (i = 0; i < 8; i++)
			rd(agss_pkg::ADR_DATA, exp_word(5'(i % 2)), 32'h801fffff);
		rd(agss_pkg::ADR_DATA, 32'h0, 32'h80000000);
		$display("Test continuous done");
		// Internal grouping: channels 2..3, two loops, random wait
		waitV = 10 + int'($urandom % 40);
		for (i = 0; i < 8; i++)
			stExp.push_back('{5'(2 + i % 2), (i == 0) ? 0 : (i == 4) ? 225 + waitV : 125});
		wb_xfer(1'b1, agss_pkg::ADR_CHAN, 32'h0302);
		wb_xfer(1'b1, agss_pkg::ADR_LOOPS, 32'h2);
		wb_xfer(1'b1, agss_pkg::ADR_WAIT, 32'(waitV));
		wb_xfer(1'b1, agss_pkg::ADR_CTRL, 32'h3);
		wait_starts(12);
		for (i = 0; i < 4; i++)
			rd(agss_pkg::ADR_DATA, exp_word(5'(2 + i % 2)), 32'h801fffff);
		wait_starts(16);
		for (i = 0; i < 4; i++)
			rd(agss_pkg::ADR_DATA, exp_word(5'(2 + i % 2)), 32'h801fffff);
		wb_xfer(1'b1, agss_pkg::ADR_CTRL, 32'h0);
		$display("Test internal grouping done");
		// External grouping: a second edge mid-group is dropped
		for (i = 0; i < 8; i++)
			stExp.push_back('{5'(2 + i % 2), (i == 0) ? 0 : (i == 4) ? 425 : 125});
		wb_xfer(1'b1, agss_pkg::ADR_CTRL, 32'h7);
		FAR.ext_pulse(10);
		// Second edge lands in the conversion tail of the first group
		repeat (500) @(posedge mclk);
		FAR.ext_pulse(10);
		repeat (280) @(posedge mclk);
		FAR.ext_pulse(10);
		wait_starts(24);
		// Let the tail run out so the sequencer is back waiting for an edge
		repeat (120) @(posedge mclk);
		rd(agss_pkg::ADR_STAT, 32'h00010004, 32'h00ff0004);
		for (i = 0; i < 8; i++)
			rd(agss_pkg::ADR_DATA, exp_word(5'(2 + i % 2)), 32'h801fffff);
		wb_xfer(1'b1, agss_pkg::ADR_CTRL, 32'h0);
		$display("Test external grouping done");
		repeat (20) @(posedge mclk);
		check_read(32'(rdExp.size() + stExp.size()), 32'h0);
		report_and_stop();
	end
endmodule
